//--- pkg/sei_pkg.sv
package sei_pkg;

  localparam int CLK_NS        = 5;
  localparam int SCL_MAX_KHZ   = 1000;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_LOW_US   = 60;
  localparam int WAKE_HIGH_US  = 1500;
  localparam int WAKE_LOW_CYC  = (WAKE_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_HIGH_CYC = (WAKE_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W         = 20;

  localparam logic [7:0] WA_RESET = 8'h00;
  localparam logic [7:0] WA_SLEEP = 8'h01;
  localparam logic [7:0] WA_IDLE  = 8'h02;
  localparam logic [7:0] WA_CMD   = 8'h03;

  localparam logic [2:0] STG_ADDR  = 3'h0;
  localparam logic [2:0] STG_WADDR = 3'h1;
  localparam logic [2:0] STG_DATA  = 3'h2;
  localparam logic [2:0] STG_CRCL  = 3'h3;
  localparam logic [2:0] STG_CRCH  = 3'h4;
  localparam logic [2:0] STG_RDATA = 3'h5;

  localparam logic [3:0]  ACK_BIT   = 4'h8;
  localparam logic [1:0]  PH_SAMPLE = 2'h1;
  localparam logic [1:0]  PH_LAST   = 2'h3;
  localparam logic        SYNC_RST  = 1'b1;
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [15:0] CRC_POLY  = 16'h8005;

  typedef enum logic [1:0] {
    OP_WAKE  = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2
  } sei_op_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_WAKE_LO = 7'h02,
    ST_WAKE_HI = 7'h04,
    ST_START   = 7'h08,
    ST_BIT     = 7'h10,
    ST_LOAD    = 7'h20,
    ST_STOP    = 7'h40
  } sei_state_t;

  typedef struct packed {
    sei_op_t    op;
    logic [7:0] wordAddr;
    logic [7:0] len;
    logic       addCrc;
  } sei_cmd_t;

  typedef struct packed {
    logic       nack;
    logic [7:0] count;
  } sei_rsp_t;

  // data bits enter lsb first
  function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = data[i] ^ c[15];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

endpackage

//--- rtl/sei_sync.sv
`timescale 1ns/1ps
module sei_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clock,
  input  logic             rstn,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import sei_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      meta_ff <= {WIDTH{SYNC_RST}};
      sync_ff <= {WIDTH{SYNC_RST}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

//--- rtl/sei_host_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Device wakes on long low, then delay.
// R2: Asleep device ignores all but wake pulse.
// R3: Device ignores clock line while idle/asleep.
// R4: Host holds data low for wake time.
// R5: Wake may use slow zero byte.
// R6: Awake device ignores further wake pulses.
// R7: Sleep or idle after slow foreign traffic.
// R8: Data changes only while clock low.
// R9: Start condition precedes every transfer.
// R10: Device ends transaction on stop condition.
// R11: Host ends every packet with stop.
// R12: Receiver pulls data low to acknowledge.
// R13: Released ninth bit means not-acknowledge.
// R14: Device matches upper seven address bits.
// R15: Write order: start, address, word, data, stop.
// R16: Command delivery uses command word address.
// R17: Group is count, packet, two-byte CRC.
// R18: Device buffers command bytes as FIFO.
// R19: Device drops bytes beyond group count.
// R20: Device drives data line open drain only.
// R21: Host releases data while device transmits.
// R22: Bus clock at most one megahertz.
// R23: Device decodes reset, sleep, idle, command.
// R24: Device refuses reads while busy or partial.
// R25: Wake times are parameterised cycle counts.
module sei_host_ctrl #(
  parameter int WAKE_LOW_CYC_P  = sei_pkg::WAKE_LOW_CYC,
  parameter int WAKE_HIGH_CYC_P = sei_pkg::WAKE_HIGH_CYC,
  parameter int QTR_CYC_P       = sei_pkg::QTR_CYC
) (
  input  logic              clock,
  input  logic              rstn,
  input  logic [6:0]        devAddr,
  input  logic              cmdValid,
  output logic              cmdReady,
  input  sei_pkg::sei_cmd_t cmd,
  input  logic              wrValid,
  output logic              wrReady,
  input  logic [7:0]        wrData,
  output logic              rdValid,
  output logic [7:0]        rdData,
  output logic              rspValid,
  output sei_pkg::sei_rsp_t rsp,
  output logic              scl,
  input  logic              sdaIn,
  output logic              sdaOut,
  output logic              sdaOe
);
  import sei_pkg::*;

  sei_state_t       state_ff;
  sei_cmd_t         cmd_ff;
  sei_rsp_t         rsp_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] tmrLim;
  logic [TMR_W-1:0] lowRun_ff;
  logic [TMR_W-1:0] hiRun_ff;
  logic [1:0]       ph_ff;
  logic [3:0]       bit_ff;
  logic [2:0]       stage_ff;
  logic [7:0]       sh_ff;
  logic [7:0]       cnt_ff;
  logic [7:0]       byteCnt_ff;
  logic [7:0]       rdData_ff;
  logic [15:0]      crc_ff;
  logic             nack_ff;
  logic             samp_ff;
  logic             scl_ff;
  logic             sdaLow_ff;
  logic             ctlPhase_ff;
  logic             rdValid_ff;
  logic             rspValid_ff;
  logic             nxt_scl;
  logic             nxt_sdaLow;
  logic             sdaSync;
  logic             tmrDone;
  logic             busPhase;
  logic             phEnd;
  logic             rxMode;
  logic             lastRx;
  logic             rxDone;
  logic             finish;

  sei_sync #(
    .WIDTH (1)
  ) uSdaSync (
    .clock (clock),
    .rstn  (rstn),
    .din   (sdaIn),
    .dout  (sdaSync)
  );

  assign busPhase = (state_ff == ST_START) || (state_ff == ST_BIT) || (state_ff == ST_STOP);
  assign tmrDone  = (tmr_ff == tmrLim);
  assign phEnd    = busPhase && tmrDone && (ph_ff == PH_LAST);
  assign rxMode   = (stage_ff == STG_RDATA);
  assign lastRx   = rxMode && (cnt_ff == 8'h01);
  assign rxDone   = (state_ff == ST_BIT) && phEnd && rxMode && (bit_ff == ACK_BIT);
  assign finish   = ((state_ff == ST_WAKE_HI) && tmrDone) || ((state_ff == ST_STOP) && phEnd);
  assign cmdReady = (state_ff == ST_IDLE);
  assign wrReady  = (state_ff == ST_LOAD);

  always_comb begin
    case (state_ff)
      ST_WAKE_LO: tmrLim = TMR_W'(WAKE_LOW_CYC_P - 1); // R4
      ST_WAKE_HI: tmrLim = TMR_W'(WAKE_HIGH_CYC_P - 1); // R1
      default:    tmrLim = TMR_W'(QTR_CYC_P - 1); // R22
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn || (state_ff == ST_IDLE) || (state_ff == ST_LOAD) || tmrDone) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  // four quarter phases per bit, start and stop
  always_ff @(posedge clock) begin
    if (!rstn || !busPhase) begin
      ph_ff <= '0;
    end else if (tmrDone) begin
      ph_ff <= ph_ff + 2'h1;
    end
  end

  // sample mid way through clock high
  always_ff @(posedge clock) begin
    if (!rstn) begin
      samp_ff <= SYNC_RST;
    end else if ((state_ff == ST_BIT) && tmrDone && (ph_ff == PH_SAMPLE)) begin
      samp_ff <= sdaSync;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      cmd_ff     <= '0;
      stage_ff   <= STG_ADDR;
      bit_ff     <= '0;
      sh_ff      <= '0;
      cnt_ff     <= '0;
      byteCnt_ff <= '0;
      crc_ff     <= CRC_INIT;
      nack_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmdValid) begin
            cmd_ff     <= cmd;
            cnt_ff     <= cmd.len;
            byteCnt_ff <= '0;
            crc_ff     <= CRC_INIT;
            nack_ff    <= 1'b0;
            // wake by a held low rather than a slow zero byte
            state_ff   <= (cmd.op == OP_WAKE) ? ST_WAKE_LO : ST_START; // R5 R9
          end
        end
        ST_WAKE_LO: begin
          if (tmrDone) begin
            state_ff <= ST_WAKE_HI; // R4
          end
        end
        ST_WAKE_HI: begin
          if (tmrDone) begin
            state_ff <= ST_IDLE; // R1
          end
        end
        ST_START: begin
          if (phEnd) begin
            sh_ff    <= {devAddr, cmd_ff.op == OP_READ}; // R15
            stage_ff <= STG_ADDR;
            bit_ff   <= '0;
            state_ff <= ST_BIT;
          end
        end
        ST_LOAD: begin
          if (wrValid) begin
            sh_ff      <= wrData;
            crc_ff     <= crcByte(crc_ff, wrData); // R17
            cnt_ff     <= cnt_ff - 8'h01;
            byteCnt_ff <= byteCnt_ff + 8'h01;
            state_ff   <= ST_BIT;
          end
        end
        ST_BIT: begin
          if (phEnd && (bit_ff != ACK_BIT)) begin
            bit_ff <= bit_ff + 4'h1;
            sh_ff  <= {sh_ff[6:0], rxMode ? samp_ff : 1'b0};
          end else if (phEnd) begin
            bit_ff <= '0;
            if (rxMode) begin
              cnt_ff     <= cnt_ff - 8'h01;
              byteCnt_ff <= byteCnt_ff + 8'h01;
              if (lastRx) begin
                state_ff <= ST_STOP; // R11
              end
            end else if (samp_ff) begin
              // refused byte, e.g. read address while busy or partial
              nack_ff  <= 1'b1; // R13 R24
              state_ff <= ST_STOP; // R11
            end else begin
              case (stage_ff)
                STG_ADDR: begin
                  if (cmd_ff.op == OP_READ) begin
                    stage_ff <= STG_RDATA;
                    if (cnt_ff == 8'h00) begin
                      state_ff <= ST_STOP;
                    end
                  end else begin
                    stage_ff <= STG_WADDR;
                    sh_ff    <= cmd_ff.wordAddr; // R15 R16
                  end
                end
                STG_WADDR, STG_DATA: begin
                  // zero data bytes gives sleep, idle or reset sequences
                  if (cnt_ff != 8'h00) begin
                    stage_ff <= STG_DATA;
                    state_ff <= ST_LOAD;
                  end else if (cmd_ff.addCrc) begin
                    stage_ff <= STG_CRCL;
                    sh_ff    <= crc_ff[7:0]; // R17
                  end else begin
                    state_ff <= ST_STOP; // R7 R11
                  end
                end
                STG_CRCL: begin
                  stage_ff <= STG_CRCH;
                  sh_ff    <= crc_ff[15:8]; // R17
                end
                default: begin
                  state_ff <= ST_STOP; // R11
                end
              endcase
            end
          end
        end
        ST_STOP: begin
          if (phEnd) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    nxt_scl    = 1'b1;
    nxt_sdaLow = 1'b0;
    case (state_ff)
      ST_WAKE_LO: begin
        nxt_sdaLow = 1'b1; // R4
      end
      ST_START: begin
        nxt_scl    = (ph_ff != PH_LAST);
        nxt_sdaLow = ph_ff[1]; // R9
      end
      ST_BIT: begin
        nxt_scl = (ph_ff == 2'h1) || (ph_ff == 2'h2); // R8
        if (bit_ff == ACK_BIT) begin
          nxt_sdaLow = rxMode && !lastRx; // R12 R13
        end else begin
          nxt_sdaLow = !rxMode && !sh_ff[7]; // R21
        end
      end
      ST_LOAD: begin
        nxt_scl = 1'b0;
      end
      ST_STOP: begin
        nxt_scl    = (ph_ff != 2'h0);
        nxt_sdaLow = !ph_ff[1]; // R11
      end
      default: begin
        nxt_scl = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      scl_ff      <= 1'b1;
      sdaLow_ff   <= 1'b0;
      ctlPhase_ff <= 1'b0;
    end else begin
      scl_ff      <= nxt_scl;
      sdaLow_ff   <= nxt_sdaLow;
      ctlPhase_ff <= (state_ff != ST_BIT) && (state_ff != ST_LOAD);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdValid_ff  <= 1'b0;
      rdData_ff   <= '0;
      rspValid_ff <= 1'b0;
      rsp_ff      <= '0;
    end else begin
      rdValid_ff  <= rxDone;
      rspValid_ff <= finish;
      if (rxDone) begin
        rdData_ff <= sh_ff;
      end
      if (finish) begin
        rsp_ff.nack  <= nack_ff;
        rsp_ff.count <= byteCnt_ff;
      end
    end
  end

  // open drain: only ever pull low
  assign sdaOut   = 1'b0; // R20
  assign sdaOe    = sdaLow_ff; // R20
  assign scl      = scl_ff;
  assign rdValid  = rdValid_ff;
  assign rdData   = rdData_ff;
  assign rspValid = rspValid_ff;
  assign rsp      = rsp_ff;

  // run lengths of pin levels
  always_ff @(posedge clock) begin
    if (!rstn || !sdaLow_ff) begin
      lowRun_ff <= '0;
    end else if (!(&lowRun_ff)) begin
      lowRun_ff <= lowRun_ff + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !scl_ff) begin
      hiRun_ff <= '0;
    end else if (!(&hiRun_ff)) begin
      hiRun_ff <= hiRun_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  AST_WAKE_LOW: assert property ( // R4
    $fell(sdaLow_ff) && (state_ff == ST_WAKE_HI) |-> lowRun_ff >= WAKE_LOW_CYC_P)
    else $error("wake low pulse too short");
  AST_WAKE_HIGH: assert property ( // R1
    $rose(state_ff == ST_WAKE_HI) |=> !sdaLow_ff [*8] ##1 (state_ff == ST_WAKE_HI))
    else $error("wake high delay cut short or data pulled");
  AST_SDA_STABLE: assert property ( // R8
    $changed(sdaLow_ff) && !ctlPhase_ff |-> !scl_ff && !$past(scl_ff))
    else $error("data changed while clock high");
  AST_START_FIRST: assert property ( // R9
    cmdValid && cmdReady && (cmd.op != OP_WAKE) |=> (state_ff == ST_START))
    else $error("transfer not opened by start");
  AST_STOP_END: assert property ( // R11
    (state_ff == ST_STOP) && phEnd |-> scl_ff && !sdaLow_ff && $past(sdaLow_ff, 2 * QTR_CYC_P))
    else $error("packet not closed by stop");
  AST_ACK_RX: assert property ( // R12
    (state_ff == ST_BIT) && rxMode && (bit_ff == ACK_BIT) && !lastRx && (ph_ff == 2'h2)
    |-> sdaLow_ff && scl_ff)
    else $error("received byte not acknowledged");
  AST_NACK_LAST: assert property ( // R13
    (state_ff == ST_BIT) && lastRx && (bit_ff == ACK_BIT) && (ph_ff == 2'h2)
    |-> !sdaLow_ff && scl_ff)
    else $error("last read byte acknowledged");
  AST_ADDR_FIRST: assert property ( // R15
    $past(state_ff == ST_START) && (state_ff == ST_BIT)
    |-> (stage_ff == STG_ADDR) && (sh_ff[7:1] == devAddr) && (sh_ff[0] == (cmd_ff.op == OP_READ)))
    else $error("first byte is not the device address");
  AST_WORD_ADDR: assert property ( // R16
    $past(stage_ff == STG_ADDR) && (stage_ff == STG_WADDR) |-> cmd_ff.op == OP_WRITE)
    else $error("word address sent on a read");
  AST_WADDR_VAL: assert property ( // R16
    $past(stage_ff == STG_ADDR) && (stage_ff == STG_WADDR) |-> sh_ff == cmd_ff.wordAddr)
    else $error("word address byte differs from command");
  AST_CRC_TAIL: assert property ( // R17
    $past(stage_ff == STG_CRCL) && (stage_ff == STG_CRCH) |-> cmd_ff.addCrc && (sh_ff == crc_ff[15:8]))
    else $error("crc tail wrong");
  AST_RX_RELEASE: assert property ( // R21
    (state_ff == ST_BIT) && rxMode && (bit_ff != ACK_BIT) && (ph_ff != 2'h0) |-> !sdaLow_ff)
    else $error("data driven while device transmits");
  AST_SCL_HIGH: assert property ( // R22
    $fell(scl_ff) |-> hiRun_ff >= 2 * QTR_CYC_P)
    else $error("clock high phase too short");

  COV_WAKE: cover property ((state_ff == ST_WAKE_HI) && tmrDone);
  COV_WRITE_CRC: cover property ((stage_ff == STG_CRCH) && phEnd ##[1:300] rspValid && !rsp.nack);
  COV_READ: cover property (rxDone && lastRx);
  COV_NACK: cover property (rspValid && rsp.nack);

endmodule

//--- bench/sei_dev_model.sv
`timescale 1ns/1ps
module sei_dev_model #(
  parameter logic [6:0] ADDR = 7'h30,
  parameter int         WLO  = 40,
  parameter int         WHI  = 50,
  parameter int         BUSY = 2000
) (
  input  logic clock,
  input  logic scl,
  input  logic sda,
  output logic pullLow
);
  logic [7:0] resp [4] = '{8'h04, 8'h00, 8'h5A, 8'hC3};
  logic [7:0] rxBuf_ff [16];
  logic [7:0] sh_ff;
  logic [7:0] wa_ff;
  logic       aw_ff = 0, busy_ff = 0, act_ff = 0, rd_ff = 0, slp_ff = 0;
  logic       sclP_ff = 1, sdaP_ff = 1, ok;
  int         wlo_ff = 0, whi_ff = 0, bsy_ff = 0, bits_ff = 0, nb_ff = 0;
  int         rxCnt_ff = 0, rdPtr_ff = 0;
  wire        part = rxCnt_ff > 0 && rxCnt_ff < rxBuf_ff[0];
  initial pullLow = 1'b0;

  always @(posedge clock) begin
    sclP_ff <= scl;
    sdaP_ff <= sda;
    if (!aw_ff) begin
      wlo_ff <= sda ? 0 : wlo_ff + 1;
      if (sda && !sdaP_ff && wlo_ff >= WLO) whi_ff <= 1;
      if (whi_ff > 0) whi_ff <= whi_ff + 1;
      if (whi_ff == WHI) begin
        aw_ff <= 1;
        whi_ff <= 0;
        act_ff <= 0;
      end
    end else begin
      if (busy_ff) bsy_ff <= bsy_ff + 1;
      if (busy_ff && bsy_ff == BUSY) begin
        busy_ff <= 0;
        rxCnt_ff <= 0;
        rdPtr_ff <= 0;
      end
      if (scl && sclP_ff && sdaP_ff && !sda) begin
        act_ff <= 1;
        rd_ff <= 0;
        bits_ff <= 0;
        nb_ff <= 0;
      end else if (scl && sclP_ff && !sdaP_ff && sda) begin
        act_ff <= 0;
        if (!busy_ff && rxCnt_ff > 0 && rxCnt_ff == rxBuf_ff[0]) begin
          busy_ff <= 1;
          bsy_ff <= 0;
        end
        if (slp_ff) begin
          aw_ff <= 0;
          slp_ff <= 0;
          rxCnt_ff <= 0;
        end
      end else if (act_ff && scl && !sclP_ff) begin
        sh_ff <= {sh_ff[6:0], sda};
        bits_ff <= bits_ff + 1;
        if (rd_ff && nb_ff > 0 && bits_ff == 8 && sda) act_ff <= 0;
      end else if (act_ff && !scl && sclP_ff) begin
        if (bits_ff == 9) begin
          bits_ff <= 0;
          nb_ff <= nb_ff + 1;
          pullLow <= rd_ff && !resp[rdPtr_ff%4][7];
        end else if (rd_ff && nb_ff > 0) begin
          pullLow <= bits_ff < 8 && !resp[rdPtr_ff%4][7-bits_ff];
          if (bits_ff == 8) rdPtr_ff <= rdPtr_ff + 1;
        end else if (bits_ff == 8) begin
          ok = nb_ff > 0 || sh_ff[7:1] == ADDR && !(sh_ff[0] && (busy_ff || part));
          pullLow <= ok;
          act_ff <= ok;
          if (nb_ff == 0) rd_ff <= sh_ff[0];
          if (nb_ff == 1) begin
            wa_ff <= sh_ff;
            slp_ff <= sh_ff == 8'h01 || sh_ff == 8'h02;
            if (sh_ff == 8'h00) begin
              rdPtr_ff <= 0;
              rxCnt_ff <= 0;
            end
          end
          if (nb_ff > 1 && wa_ff == 8'h03 && !busy_ff && (rxCnt_ff == 0 || part)) begin
            rxBuf_ff[rxCnt_ff] <= sh_ff;
            rxCnt_ff <= rxCnt_ff + 1;
          end
        end
      end
    end
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import sei_pkg::*;
  localparam int         WLO = 40;
  localparam int         WHI = 60;
  localparam logic [6:0] DEV = 7'h30;
  logic        clock, rstn, cmdValid, cmdReady, wrValid, wrReady, rdValid, rspValid;
  logic        scl, sdaIn, sdaOut, sdaOe, pullLow, take;
  logic [6:0]  devAddr;
  logic [7:0]  wrData, rdData;
  logic [15:0] crc;
  sei_cmd_t    cmd;
  sei_rsp_t    rsp;
  int          mismatches = 0, n_tests = 0, cyc;
  logic [7:0]  tx [$];
  logic [7:0]  rq [$];

  // open-drain wire with pull-up
  assign sdaIn = (sdaOe === 1'b1 || pullLow) ? 1'b0 : 1'b1;
  sei_host_ctrl #(.WAKE_LOW_CYC_P(WLO), .WAKE_HIGH_CYC_P(WHI), .QTR_CYC_P(4)) DUT (
    .clock(clock), .rstn(rstn), .devAddr(devAddr), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .rspValid(rspValid),
    .rsp(rsp), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
  sei_dev_model #(.ADDR(DEV)) M (.clock(clock), .scl(scl), .sda(sdaIn), .pullLow(pullLow));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (rdValid === 1'b1) rq.push_back(rdData);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkRsp(input sei_rsp_t got, input sei_rsp_t exp);
    chk(32'(got), 32'(exp));
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one command through the user port, bytes fed from tx
  task automatic run(input sei_op_t op, input logic [7:0] wa, input logic [7:0] n,
                     input logic c);
    int k;
    k = 0;
    rq = {};
    cmd = '{op, wa, n, c};
    cmdValid = 1'b1;
    @(posedge clock);
    #1;
    cmdValid = 1'b0;
    cyc = 0;
    while (rspValid !== 1'b1 && cyc < 30000) begin
      wrValid = op == OP_WRITE && k < n;
      wrData = wrValid ? tx[k] : 8'h00;
      take = wrValid && wrReady === 1'b1;
      @(posedge clock);
      #1;
      if (take) k++;
      cyc++;
    end
    wrValid = 1'b0;
    if (cyc >= 30000) mismatches++;
  endtask

  function automatic logic [15:0] crcRef(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] c;
    logic [15:0] d;
    c = 16'h0000;
    d = {b, a};
    for (int i = 0; i < 16; i++) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction

  initial begin
    #400000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    rstn = 1'b0;
    cmdValid = 1'b0;
    wrValid = 1'b0;
    wrData = 8'h00;
    cmd = '0;
    devAddr = DEV;
    repeat (3) @(posedge clock);
    #1 rstn = 1'b1;
    chk({scl, sdaOut, sdaOe, cmdReady, wrReady, rspValid}, 6'h24);
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    run(OP_WAKE, 8'h00, 8'h00, 1'b0);
    chk(cyc, WLO + WHI);
    chkRsp(rsp, '{1'b0, 8'h00});
    devAddr = DEV ^ 7'h01;
    run(OP_WRITE, WA_CMD, 8'h00, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    devAddr = DEV;
    tx = '{8'h04, 8'h11};
    run(OP_WRITE, WA_CMD, 8'h02, 1'b0);
    chkRsp(rsp, '{1'b0, 8'h02});
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    run(OP_WAKE, 8'h00, 8'h00, 1'b0);
    tx = '{8'h22, 8'h33, 8'h44};
    run(OP_WRITE, WA_CMD, 8'h03, 1'b0);
    chkRsp(rsp, '{1'b0, 8'h03});
    chk(M.rxCnt_ff, 4);
    chk(M.rxBuf_ff[3], 8'h33);
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    repeat (2100) @(posedge clock);
    #1;
    run(OP_READ, 8'h00, 8'h04, 1'b0);
    chkRsp(rsp, '{1'b0, 8'h04});
    for (int i = 0; i < 4; i++) chk(rq[i], M.resp[i]);
    tx = '{8'h04, 8'h77};
    run(OP_WRITE, WA_CMD, 8'h02, 1'b0);
    tx = {};
    run(OP_WRITE, WA_RESET, 8'h00, 1'b0);
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b0, 8'h01});
    chk(rq[0], M.resp[0]);
    tx = '{8'h04, 8'hA5};
    run(OP_WRITE, WA_CMD, 8'h02, 1'b1);
    crc = crcRef(8'h04, 8'hA5);
    chk({M.rxBuf_ff[2], M.rxBuf_ff[3]}, {crc[7:0], crc[15:8]});
    repeat (2100) @(posedge clock);
    #1;
    tx = {};
    run(OP_WRITE, WA_SLEEP, 8'h00, 1'b0);
    chkRsp(rsp, '{1'b0, 8'h00});
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    run(OP_WAKE, 8'h00, 8'h00, 1'b0);
    run(OP_WRITE, WA_IDLE, 8'h00, 1'b0);
    run(OP_READ, 8'h00, 8'h01, 1'b0);
    chkRsp(rsp, '{1'b1, 8'h00});
    tally_and_finish;
  end
endmodule
